// ===== core/fe_flash_end.sv
// Flash end: page buffer, array, partition busy and error log.
`timescale 1ns/10ps
`include "fe_map.svh"
// How it works
// - Reads proceed in partitions not being written.
// - Program partition follows interlock address only.
// - Erase marks partitions of selected unlocked blocks.
// - Word or double word writes fill buffer.
// - Page takes four, quad-page sixteen double words.
// - Every read returns one whole page.
// - Test info block has its own lock.
// - Master codes 29-bit address with 64-bit data.
// - Master codes 30-bit address with 32-bit data.
// - Store received data and checkbits unchanged.
// - Return stored data and checkbits undecoded.
// - Master decodes, corrects single errors before use.
// - Optional checkbit check on store.
// - Master checks against its retained address.
// - Single errors corrected and logged; multi escalated.
// - Granules of 64 or 32 data bits.
// - Group one, ee clear: checkstop or machine check vector.
// - Group one data fault: storage vector, syndrome bit.
// - Group one fetch fault: instruction storage vector.
// - Group two always machine check vector.
// - Uncleared syndrome flag retakes machine check.
// - Twenty correctable entries, one uncorrectable entry.
module fe_flash_end
  import fe_pkg::*;
(
  input logic hclk, // System clock.
  input logic hresetn, // Asynchronous reset, active low.
  fe_link_if.flash lk, // Link to the bus master end.
  input logic [7:0] blk_sel, // Erase select, one bit per block.
  input logic [7:0] blk_lock, // Program and erase lock per block.
  input logic tib_lock, // Program lock of the test info block.
  input logic store_chk_en, // Verify checkbits on store.
  input logic meu_clr, // Clears the error log.
  input logic [4:0] ent_idx, // Correctable entry to show.
  output logic [4:0] part_busy, // Partitions being written.
  output logic [4:0] ce_cnt, // Correctable entries in use.
  output logic ce_full, // Correctable table full.
  output logic ue_valid, // Uncorrectable entry in use.
  output logic [31:0] ue_addr, // Uncorrectable error address.
  output logic [31:0] ent_addr // Address of entry ent_idx.
);

  logic [255:0] arr_d_r [0:`FE_TIB_PG];
  logic [255:0] arr_d_nxt [0:`FE_TIB_PG];
  logic [63:0] arr_c_r [0:`FE_TIB_PG];
  logic [63:0] arr_c_nxt [0:`FE_TIB_PG];
  logic [63:0] buf_d_r [0:`FE_BUF_DW-1];
  logic [63:0] buf_d_nxt [0:`FE_BUF_DW-1];
  logic [15:0] buf_c_r [0:`FE_BUF_DW-1];
  logic [15:0] buf_c_nxt [0:`FE_BUF_DW-1];
  logic [4:0] busy_r, busy_nxt;
  logic [7:0] tmr_r, tmr_nxt;
  logic ack_r, ack_nxt, err_r, err_nxt;
  logic [255:0] rpage_r, rpage_nxt;
  logic [63:0] rcb_r, rcb_nxt;
  logic [31:0] ce_a_r [0:`FE_CE_ENTRIES-1];
  logic [31:0] ce_a_nxt [0:`FE_CE_ENTRIES-1];
  logic [4:0] ce_cnt_r, ce_cnt_nxt;
  logic full_r, full_nxt, ue_v_r, ue_v_nxt;
  logic [31:0] ue_a_r, ue_a_nxt, ent_r, ent_nxt;
  logic tib;
  logic [3:0] pg;
  logic [2:0] pt;
  logic [7:0] cb_chk;
  logic [8:0] hit;
  logic dup;

  // ----------------------------------------------------------------------
  // Target decode
  // ----------------------------------------------------------------------
  assign tib = lk.addr[`FE_TIB_BIT];
  assign pg = tib ? 4'(`FE_TIB_PG) : {1'b0, lk.addr[`FE_PG_F]};
  assign pt = tib ? 3'(`FE_TIB_PT) : {1'b0, lk.addr[`FE_PT_F]};
  assign cb_chk = lk.dw ? fe_enc({3'h0, lk.addr[`FE_A29], lk.wdata})
                        : fe_enc({34'h0, lk.addr[`FE_A30], lk.wdata[31:0]});

  // Pages touched by a program: only the interlock address counts.
  for (genvar p = 0; p < `FE_TIB_PG; p++)
  begin : g_hit
    assign hit[p] = !tib && (lk.quad ? lk.addr[`FE_QUAD_BIT] == 1'(p >> 2)
                                     : lk.addr[`FE_PG_F] == 3'(p));
  end
  assign hit[`FE_TIB_PG] = tib;

  // ----------------------------------------------------------------------
  // Array, buffer and partition busy
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [1:0] bl;
    logic prot;
    bl = 2'h0;
    prot = 1'b0;
    arr_d_nxt = arr_d_r;
    arr_c_nxt = arr_c_r;
    buf_d_nxt = buf_d_r;
    buf_c_nxt = buf_c_r;
    busy_nxt = busy_r;
    tmr_nxt = tmr_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    rpage_nxt = rpage_r;
    rcb_nxt = rcb_r;
    if (tmr_r != 8'h00)
      tmr_nxt = tmr_r - 8'h01;
    else
      busy_nxt = 5'h00;
    if (lk.req && !ack_r)
    begin
      unique case (lk.op)
        FE_READ:
          if (!busy_r[pt])
          begin
            ack_nxt = 1'b1;
            rpage_nxt = arr_d_r[pg];
            rcb_nxt = arr_c_r[pg];
          end
        FE_WRITE:
        begin
          ack_nxt = 1'b1;
          if (store_chk_en && cb_chk != lk.wcb)
            err_nxt = 1'b1;
          else if (lk.dw)
          begin
            buf_d_nxt[lk.addr[`FE_DW_F]] = lk.wdata;
            buf_c_nxt[lk.addr[`FE_DW_F]] = {lk.wcb, lk.wcb};
          end
          else
          begin
            buf_d_nxt[lk.addr[`FE_DW_F]][32 * lk.addr[`FE_LANE_BIT] +: 32] =
              lk.wdata[31:0];
            buf_c_nxt[lk.addr[`FE_DW_F]][8 * lk.addr[`FE_LANE_BIT] +: 8] =
              lk.wcb;
          end
        end
        FE_PROG:
          if (busy_r == 5'h00)
          begin
            ack_nxt = 1'b1;
            if (tib)
              prot = tib_lock || lk.quad;
            else
              prot = |(hit[`FE_TIB_PG-1:0] & blk_lock);
            err_nxt = prot;
            if (!prot)
            begin
              for (int p = 0; p <= `FE_TIB_PG; p++)
                if (hit[p])
                begin
                  bl = lk.quad ? 2'(p) : lk.addr[`FE_PIB_F];
                  for (int j = 0; j < 4; j++)
                  begin
                    arr_d_nxt[p][64 * j +: 64] = arr_d_r[p][64 * j +: 64]
                      & buf_d_r[{bl, 2'(j)}];
                    arr_c_nxt[p][16 * j +: 16] = arr_c_r[p][16 * j +: 16]
                      & buf_c_r[{bl, 2'(j)}];
                  end
                  if (p == `FE_TIB_PG)
                    busy_nxt[`FE_TIB_PT] = 1'b1;
                  else
                    busy_nxt[p / 2] = 1'b1;
                end
              tmr_nxt = 8'(`FE_PROG_CYC);
              buf_d_nxt = '{default: '1};
              buf_c_nxt = '{default: '1};
            end
          end
        FE_ERASE:
          if (busy_r == 5'h00)
          begin
            ack_nxt = 1'b1;
            for (int p = 0; p < `FE_TIB_PG; p++)
              if (blk_sel[p] && !blk_lock[p])
              begin
                arr_d_nxt[p] = '1;
                arr_c_nxt[p] = '1;
                busy_nxt[p / 2] = 1'b1;
              end
            tmr_nxt = 8'(`FE_ERASE_CYC);
          end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      arr_d_r <= '{default: '1};
      arr_c_r <= '{default: '1};
      buf_d_r <= '{default: '1};
      buf_c_r <= '{default: '1};
      busy_r <= 5'h00;
      tmr_r <= 8'h00;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rpage_r <= '0;
      rcb_r <= 64'h0;
    end
    else
    begin
      arr_d_r <= arr_d_nxt;
      arr_c_r <= arr_c_nxt;
      buf_d_r <= buf_d_nxt;
      buf_c_r <= buf_c_nxt;
      busy_r <= busy_nxt;
      tmr_r <= tmr_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rpage_r <= rpage_nxt;
      rcb_r <= rcb_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Error log
  // ----------------------------------------------------------------------
  always_comb
  begin
    ce_a_nxt = ce_a_r;
    ce_cnt_nxt = ce_cnt_r;
    ue_v_nxt = ue_v_r;
    ue_a_nxt = ue_a_r;
    dup = 1'b0;
    for (int i = 0; i < `FE_CE_ENTRIES; i++)
      if (5'(i) < ce_cnt_r && ce_a_r[i] == lk.rep_addr)
        dup = 1'b1;
    if (meu_clr)
    begin
      ce_cnt_nxt = 5'h00;
      ue_v_nxt = 1'b0;
      dup = 1'b0;
    end
    if (lk.rep_ce && !dup && ce_cnt_nxt < 5'(`FE_CE_ENTRIES))
    begin
      ce_a_nxt[ce_cnt_nxt] = lk.rep_addr;
      ce_cnt_nxt = ce_cnt_nxt + 5'h01;
    end
    if (lk.rep_ue && !ue_v_nxt)
    begin
      ue_v_nxt = 1'b1;
      ue_a_nxt = lk.rep_addr;
    end
    full_nxt = ce_cnt_nxt == 5'(`FE_CE_ENTRIES);
    ent_nxt = ent_idx < ce_cnt_r ? ce_a_r[ent_idx] : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ce_a_r <= '{default: 32'h0};
      ce_cnt_r <= 5'h00;
      full_r <= 1'b0;
      ue_v_r <= 1'b0;
      ue_a_r <= 32'h0;
      ent_r <= 32'h0;
    end
    else
    begin
      ce_a_r <= ce_a_nxt;
      ce_cnt_r <= ce_cnt_nxt;
      full_r <= full_nxt;
      ue_v_r <= ue_v_nxt;
      ue_a_r <= ue_a_nxt;
      ent_r <= ent_nxt;
    end
  end

  assign lk.ack = ack_r;
  assign lk.err = err_r;
  assign lk.rpage = rpage_r;
  assign lk.rcb = rcb_r;
  assign part_busy = busy_r;
  assign ce_cnt = ce_cnt_r;
  assign ce_full = full_r;
  assign ue_valid = ue_v_r;
  assign ue_addr = ue_a_r;
  assign ent_addr = ent_r;

endmodule : fe_flash_end

// ===== core/fe_link_if.sv
// Link between the bus master end and the flash end.
`timescale 1ns/10ps
interface fe_link_if;
  import fe_pkg::*;
  logic req;
  fe_op_t op;
  logic dw;
  logic quad;
  logic [31:0] addr;
  logic [63:0] wdata;
  logic [7:0] wcb;
  logic ack;
  logic err;
  logic [255:0] rpage;
  logic [63:0] rcb;
  logic rep_ce;
  logic rep_ue;
  logic [31:0] rep_addr;
  modport flash (input req, op, dw, quad, addr, wdata, wcb, rep_ce, rep_ue,
                 rep_addr, output ack, err, rpage, rcb);
  modport master (output req, op, dw, quad, addr, wdata, wcb, rep_ce, rep_ue,
                  rep_addr, input ack, err, rpage, rcb);
endinterface : fe_link_if

// ===== core/fe_map.svh
// Address map, field positions and timing counts of the flash ECC path.
`ifndef FE_MAP_SVH
`define FE_MAP_SVH
`define FE_CLK_NS 20
`define FE_PROG_NS 2000
`define FE_ERASE_NS 4000
`define FE_PROG_CYC ((`FE_PROG_NS + `FE_CLK_NS - 1) / `FE_CLK_NS)
`define FE_ERASE_CYC ((`FE_ERASE_NS + `FE_CLK_NS - 1) / `FE_CLK_NS)
`define FE_TIB_BIT 8
`define FE_TIB_PG 8
`define FE_TIB_PT 4
`define FE_BUF_DW 16
`define FE_CE_ENTRIES 20
`define FE_PG_F 7:5
`define FE_PT_F 7:6
`define FE_PIB_F 6:5
`define FE_DW_F 6:3
`define FE_QUAD_BIT 7
`define FE_LANE_BIT 2
`define FE_RDW_F 4:3
`define FE_RW_F 4:2
`define FE_A29 31:3
`define FE_A30 31:2
`define FE_V29 92:64
`define FE_V30 61:32
`define FE_HT_NS 1
`define FE_R_CTRL 8'h00
`define FE_R_ADDR 8'h04
`define FE_R_WDLO 8'h08
`define FE_R_WDHI 8'h0C
`define FE_R_INJ 8'h10
`define FE_R_RDLO 8'h14
`define FE_R_RDHI 8'h18
`define FE_R_STAT 8'h1C
`endif

// ===== core/fe_master_end.sv
// Bus master end: checkbit coding, decode, correction and exception routing.
`timescale 1ns/10ps
`include "fe_map.svh"
module fe_master_end
  import fe_pkg::*;
(
  input logic hclk, // System clock.
  input logic hresetn, // Asynchronous reset, active low.
  input logic hsel, // AHB-Lite slave select.
  input logic [31:0] haddr, // AHB-Lite address.
  input logic [1:0] htrans, // AHB-Lite transfer type.
  input logic hwrite, // AHB-Lite write.
  input logic [2:0] hsize, // AHB-Lite size, words only.
  input logic [31:0] hwdata, // AHB-Lite write data.
  input logic hready, // AHB-Lite bus ready.
  output logic hreadyout, // AHB-Lite slave ready.
  output logic [31:0] hrdata, // AHB-Lite read data.
  output logic hresp, // AHB-Lite response, always OKAY.
  output logic checkstop, // Checkstop state entered.
  output logic mc_vec, // Machine check vector taken.
  output logic ds_vec, // Data storage vector taken.
  output logic is_vec, // Instruction storage vector taken.
  output logic esr_ext, // External termination syndrome bit.
  fe_link_if.master lk // Link to the flash end.
);

  fe_mst_t st_r, st_nxt;
  fe_ctrl_t ctl_r, ctl_nxt;
  logic [31:0] addr_r, addr_nxt, hrdata_r, hrdata_nxt;
  logic [63:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [7:0] inj_r, inj_nxt, wcb_r, wcb_nxt, dpa_r, dpa_nxt, rcb;
  logic dph_r, dph_nxt, req_r, req_nxt, ce_r, ce_nxt, ue_r, ue_nxt;
  logic serr_r, serr_nxt, cs_r, cs_nxt, mcs_r, mcs_nxt, esr_r, esr_nxt;
  logic mc_r, mc_nxt, ds_r, ds_nxt, is_r, is_nxt;
  logic rce_r, rce_nxt, rue_r, rue_nxt, abad;
  logic [95:0] vec;
  fe_dec_t dr;
  fe_ctrl_t wc;
  fe_stat_t stat;

  // ----------------------------------------------------------------------
  // Read path decode against the retained address
  // ----------------------------------------------------------------------
  assign rcb = ctl_r.dw ? lk.rcb[16 * addr_r[`FE_RDW_F] +: 8]
                        : lk.rcb[8 * addr_r[`FE_RW_F] +: 8];
  assign vec = ctl_r.dw
    ? {3'h0, addr_r[`FE_A29], lk.rpage[64 * addr_r[`FE_RDW_F] +: 64]}
    : {34'h0, addr_r[`FE_A30], lk.rpage[32 * addr_r[`FE_RW_F] +: 32]};
  assign dr = fe_dec(vec, rcb);
  assign abad = ctl_r.dw ? dr.vec[`FE_V29] != addr_r[`FE_A29]
                         : dr.vec[`FE_V30] != addr_r[`FE_A30];
  assign wc = fe_ctrl_t'(hwdata);
  assign stat = '{rsvd: '0, esr_ext: esr_r, mcs: mcs_r, checkstop: cs_r,
                  store_err: serr_r, ue: ue_r, ce: ce_r,
                  busy: st_r == MS_WAIT};

  // ----------------------------------------------------------------------
  // Registers, request sequencing and escalation
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    ctl_nxt = ctl_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    inj_nxt = inj_r;
    rd_nxt = rd_r;
    wcb_nxt = wcb_r;
    req_nxt = req_r;
    {ce_nxt, ue_nxt, serr_nxt, cs_nxt} = {ce_r, ue_r, serr_r, cs_r};
    mcs_nxt = mcs_r;
    esr_nxt = esr_r;
    {ds_nxt, is_nxt, rce_nxt, rue_nxt} = 4'h0;
    mc_nxt = mcs_r && ctl_r.me && ctl_r.grp2;
    dph_nxt = hsel && htrans[`FE_HT_NS] && hready && hwrite;
    dpa_nxt = haddr[7:0];
    hrdata_nxt = hrdata_r;
    if (hsel && htrans[`FE_HT_NS] && hready && !hwrite)
      unique case (haddr[7:0])
        `FE_R_CTRL: hrdata_nxt = 32'(ctl_r);
        `FE_R_ADDR: hrdata_nxt = addr_r;
        `FE_R_WDLO: hrdata_nxt = wd_r[31:0];
        `FE_R_WDHI: hrdata_nxt = wd_r[63:32];
        `FE_R_INJ: hrdata_nxt = {24'h0, inj_r};
        `FE_R_RDLO: hrdata_nxt = rd_r[31:0];
        `FE_R_RDHI: hrdata_nxt = rd_r[63:32];
        `FE_R_STAT: hrdata_nxt = 32'(stat);
        default: hrdata_nxt = 32'h0;
      endcase
    if (dph_r && dpa_r == `FE_R_CTRL && wc.mc_clr)
    begin
      mcs_nxt = 1'b0;
      esr_nxt = 1'b0;
    end
    if (dph_r && st_r == MS_IDLE)
      unique case (dpa_r)
        `FE_R_CTRL:
          if (wc.go)
          begin
            ctl_nxt = wc;
            wcb_nxt = inj_r ^ (wc.dw
              ? fe_enc({3'h0, addr_r[`FE_A29], wd_r})
              : fe_enc({34'h0, addr_r[`FE_A30], wd_r[31:0]}));
            req_nxt = 1'b1;
            {ce_nxt, ue_nxt, serr_nxt} = 3'h0;
            st_nxt = MS_WAIT;
          end
        `FE_R_ADDR: addr_nxt = hwdata;
        `FE_R_WDLO: wd_nxt[31:0] = hwdata;
        `FE_R_WDHI: wd_nxt[63:32] = hwdata;
        `FE_R_INJ: inj_nxt = hwdata[7:0];
        default: ;
      endcase
    if (st_r == MS_WAIT && lk.ack)
    begin
      req_nxt = 1'b0;
      st_nxt = MS_IDLE;
      serr_nxt = lk.err;
      if (ctl_r.op == FE_READ)
      begin
        rd_nxt = ctl_r.dw ? dr.vec[63:0] : {32'h0, dr.vec[31:0]};
        ce_nxt = dr.ce && !abad;
        ue_nxt = dr.ue || abad;
        rce_nxt = dr.ce && !abad;
        rue_nxt = dr.ue || abad;
        if (dr.ue || abad)
        begin
          if (ctl_r.grp2)
          begin
            mc_nxt = 1'b1;
            mcs_nxt = mcs_nxt || ctl_r.me;
          end
          else if (!ctl_r.ee)
          begin
            mc_nxt = ctl_r.me;
            cs_nxt = !ctl_r.me;
          end
          else if (ctl_r.fetch)
            is_nxt = 1'b1;
          else
          begin
            ds_nxt = 1'b1;
            esr_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= MS_IDLE;
      ctl_r <= '0;
      {addr_r, hrdata_r, wd_r, rd_r} <= '0;
      {inj_r, wcb_r, dpa_r} <= '0;
      {dph_r, req_r, ce_r, ue_r, serr_r, cs_r, mcs_r, esr_r} <= 8'h00;
      {mc_r, ds_r, is_r, rce_r, rue_r} <= 5'h00;
    end
    else
    begin
      st_r <= st_nxt;
      ctl_r <= ctl_nxt;
      {addr_r, hrdata_r, wd_r, rd_r} <= {addr_nxt, hrdata_nxt, wd_nxt, rd_nxt};
      {inj_r, wcb_r, dpa_r} <= {inj_nxt, wcb_nxt, dpa_nxt};
      {dph_r, req_r, ce_r, ue_r} <= {dph_nxt, req_nxt, ce_nxt, ue_nxt};
      {serr_r, cs_r, mcs_r, esr_r} <= {serr_nxt, cs_nxt, mcs_nxt, esr_nxt};
      {mc_r, ds_r, is_r} <= {mc_nxt, ds_nxt, is_nxt};
      {rce_r, rue_r} <= {rce_nxt, rue_nxt};
    end
  end

  assign hreadyout = hresetn;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign {checkstop, mc_vec, ds_vec, is_vec, esr_ext} =
    {cs_r, mc_r, ds_r, is_r, esr_r};
  assign lk.req = req_r;
  assign lk.op = ctl_r.op;
  assign lk.dw = ctl_r.dw;
  assign lk.quad = ctl_r.quad;
  assign lk.addr = addr_r;
  assign lk.wdata = wd_r;
  assign lk.wcb = wcb_r;
  assign lk.rep_ce = rce_r;
  assign lk.rep_ue = rue_r;
  assign lk.rep_addr = addr_r;

endmodule : fe_master_end

// ===== core/fe_pkg.sv
// Types and checkbit functions shared by both ends of the flash ECC path.
package fe_pkg;
  typedef enum logic [1:0] {FE_READ, FE_WRITE, FE_PROG, FE_ERASE} fe_op_t;
  typedef enum logic {MS_IDLE, MS_WAIT} fe_mst_t;
  typedef struct packed {
    logic [21:0] rsvd;
    logic mc_clr;
    logic fetch;
    logic me;
    logic ee;
    logic grp2;
    logic quad;
    logic dw;
    fe_op_t op;
    logic go;
  } fe_ctrl_t;
  typedef struct packed {
    logic [24:0] rsvd;
    logic esr_ext;
    logic mcs;
    logic checkstop;
    logic store_err;
    logic ue;
    logic ce;
    logic busy;
  } fe_stat_t;
  typedef struct packed {
    logic [95:0] vec;
    logic ce;
    logic ue;
  } fe_dec_t;

  // Column of the check matrix: the i-th value that is not a power of two.
  function automatic logic [6:0] fe_col(input int i);
    int n;
    logic [6:0] r;
    n = 0;
    r = 7'h00;
    for (int k = 3; k < 128; k++)
    begin
      if ((7'(k) & (7'(k) - 7'h01)) != 7'h00)
      begin
        if (n == i)
          r = 7'(k);
        n++;
      end
    end
    return r;
  endfunction : fe_col

  function automatic logic [7:0] fe_enc(input logic [95:0] v);
    logic [6:0] p;
    p = 7'h00;
    for (int i = 0; i < 96; i++)
      if (v[i])
        p = p ^ fe_col(i);
    return {(^v) ^ (^p), p};
  endfunction : fe_enc

  function automatic fe_dec_t fe_dec(input logic [95:0] v,
                                     input logic [7:0] cb);
    logic [7:0] s;
    logic hit;
    fe_dec_t r;
    s = fe_enc(v) ^ cb;
    hit = 1'b0;
    r = '{vec: v, ce: 1'b0, ue: 1'b0};
    if (s[7])
    begin
      r.ce = 1'b1;
      for (int i = 0; i < 96; i++)
        if (s[6:0] != 7'h00 && fe_col(i) == s[6:0])
        begin
          r.vec[i] = ~v[i];
          hit = 1'b1;
        end
      if (s[6:0] != 7'h00 && !hit)
      begin
        r.ce = 1'b0;
        r.ue = 1'b1;
      end
    end
    else if (s[6:0] != 7'h00)
      r.ue = 1'b1;
    return r;
  endfunction : fe_dec
endpackage : fe_pkg

// ===== tb/fe_path_sva.sv
// Concurrent checks on the link between the two ends of the flash ECC path.
`timescale 1ns/10ps
module fe_path_sva
  import fe_pkg::*;
(
  input logic hclk, // System clock.
  input logic hresetn, // Reset, active low.
  input logic req, // Link request.
  input fe_op_t op, // Link operation.
  input logic [31:0] addr, // Link address.
  input logic ack, // Link acknowledge.
  input logic err, // Link refusal.
  input logic [255:0] rpage, // Returned page.
  input logic [63:0] rcb, // Returned checkbits.
  input logic rep_ce, // Correctable report.
  input logic rep_ue, // Uncorrectable report.
  input logic [31:0] rep_addr // Reported address.
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_ack_single: assert property
    (ack |=> !ack)
    else $error("ack stood longer than one cycle");
  chk_ack_cause: assert property
    (ack |-> $past(req) && !$past(ack))
    else $error("ack without a taken request");
  chk_write_ack: assert property
    (req && !ack && op == FE_WRITE |=> ack)
    else $error("write not answered in one cycle");
  chk_page_hold: assert property
    (!$stable({rpage, rcb}) |-> ack && op == FE_READ)
    else $error("page changed outside a read answer");
  chk_req_release: assert property
    (ack |=> !req)
    else $error("request held after its answer");
  chk_rep_timing: assert property
    (rep_ce || rep_ue |-> $past(ack) && $past(op) == FE_READ)
    else $error("report not one cycle after a read answer");
  chk_rep_single: assert property
    (!(rep_ce && rep_ue))
    else $error("both report kinds at once");
  chk_rep_addr: assert property
    (rep_ce || rep_ue |-> rep_addr == $past(addr))
    else $error("report address differs from request");
  cover property (ack && op == FE_READ);
  cover property (rep_ce);
  cover property (rep_ue);
  cover property (ack && err);
endmodule : fe_path_sva

// ===== tb/flash_end_to_end_ecc_path_tb.sv
// Self-checking bench for both ends of the flash ECC path.
`timescale 1ns/10ps
`include "fe_map.svh"
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module flash_end_to_end_ecc_path_tb;
  import fe_pkg::*;
  localparam logic [63:0] da = 64'h123456789ABCDEF0;
  localparam logic [63:0] db = 64'hA5A50F0F3C3C00FF;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic [7:0] blk_sel = 8'hFF, blk_lock = 8'hF0;
  logic tib_lock = 1'b1, store_chk_en = 1'b0, meu_clr = 1'b0;
  logic clr_seen = 1'b0;
  logic [4:0] ent_idx = 5'h00;
  logic hreadyout, checkstop, mc_vec, ds_vec, is_vec, esr_ext, hresp;
  logic ce_full, ue_valid, last_err;
  logic [4:0] part_busy, ce_cnt;
  logic [31:0] hrdata, ue_addr, ent_addr, st;
  logic [63:0] d;
  logic [7:0] last_wcb;
  logic [3:0] vseen = 4'h0;
  int bad_count = 0;
  int n_tests = 0;
  logic [3:0] modes [6] = '{4'h4, 4'h2, 4'hE, 4'h1, 4'h5, 4'h0};
  logic [6:0] exps [6] = '{7'h01, 7'h42, 7'h04, 7'h01, 7'h21, 7'h18};
  fe_link_if fe_link_if_i ();
  fe_master_end fe_master_end_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .checkstop(checkstop), .mc_vec(mc_vec), .ds_vec(ds_vec),
    .is_vec(is_vec), .esr_ext(esr_ext), .lk(fe_link_if_i));
  fe_flash_end fe_flash_end_i (.hclk(hclk), .hresetn(hresetn),
    .lk(fe_link_if_i), .blk_sel(blk_sel), .blk_lock(blk_lock),
    .tib_lock(tib_lock), .store_chk_en(store_chk_en), .meu_clr(meu_clr),
    .ent_idx(ent_idx), .part_busy(part_busy), .ce_cnt(ce_cnt),
    .ce_full(ce_full), .ue_valid(ue_valid), .ue_addr(ue_addr),
    .ent_addr(ent_addr));
  fe_path_sva fe_path_sva_i (.hclk(hclk), .hresetn(hresetn),
    .req(fe_link_if_i.req), .op(fe_link_if_i.op), .addr(fe_link_if_i.addr),
    .ack(fe_link_if_i.ack), .err(fe_link_if_i.err),
    .rpage(fe_link_if_i.rpage), .rcb(fe_link_if_i.rcb),
    .rep_ce(fe_link_if_i.rep_ce), .rep_ue(fe_link_if_i.rep_ue),
    .rep_addr(fe_link_if_i.rep_addr));
  initial
  begin
    forever #10 hclk = ~hclk;
  end
  // Keeps what the link carried and which vectors fired since the last clear.
  always @(posedge hclk)
  begin
    if (fe_link_if_i.ack && fe_link_if_i.op == FE_WRITE)
      last_wcb <= fe_link_if_i.wcb;
    if (fe_link_if_i.ack)
      last_err <= fe_link_if_i.err;
    vseen <= clr_seen ? 4'h0 : vseen | {checkstop, is_vec, ds_vec, mc_vec};
  end
  task automatic conclude;
    $display("n_tests %0d bad_count %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic hang;
    bad_count++;
    conclude();
  endtask : hang
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 100)
        hang();
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    st = hrdata;
  endtask : ahb
  task automatic go(input fe_op_t o, input logic [31:0] a,
                    input logic [3:0] m, input logic w = 1'b1);
    int k;
    k = 0;
    ahb(1'b1, `FE_R_ADDR, a);
    ahb(1'b1, `FE_R_CTRL, {22'h0, 1'b0, m, 1'b0, w, o, 1'b1});
    st = 32'h00000001;
    while (st[0] !== 1'b0)
    begin
      k++;
      if (k > 300)
        hang();
      ahb(1'b0, `FE_R_STAT, 32'h0);
    end
  endtask : go
  task automatic load(input logic [31:0] a, input logic [63:0] v,
                      input logic [7:0] inj, input logic w = 1'b1);
    ahb(1'b1, `FE_R_WDLO, v[31:0]);
    ahb(1'b1, `FE_R_WDHI, v[63:32]);
    ahb(1'b1, `FE_R_INJ, {24'h000000, inj});
    go(FE_WRITE, a, 4'h0, w);
  endtask : load
  task automatic readback(input logic [31:0] a);
    go(FE_READ, a, 4'h0);
    ahb(1'b0, `FE_R_RDLO, 32'h0);
    d[31:0] = st;
    ahb(1'b0, `FE_R_RDHI, 32'h0);
    d[63:32] = st;
    ahb(1'b0, `FE_R_STAT, 32'h0);
  endtask : readback
  task automatic idle_parts;
    int k;
    k = 0;
    while (part_busy !== 5'h00)
    begin
      k++;
      if (k > 500)
        hang();
      @(posedge hclk);
    end
  endtask : idle_parts
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    load(32'h48, db, 8'h83);
    go(FE_PROG, 32'h48, 4'h0);
    idle_parts();
    load(32'h08, da, 8'h00);
    go(FE_PROG, 32'h08, 4'h0);
    `CHK(part_busy, 5'h01)
    `CHK(last_err, 1'b0)
    readback(32'h48);
    `CHK(part_busy, 5'h01)
    `CHK(d, db ^ 64'h1)
    `CHK(st[2:1], 2'b01)
    `CHK(ent_addr, 32'h48)
    idle_parts();
    readback(32'h08);
    `CHK(d, da)
    `CHK(fe_link_if_i.rpage[127:64], da)
    `CHK(fe_link_if_i.rcb[31:16], {last_wcb, last_wcb})
    readback(32'h48);
    `CHK(ce_cnt, 5'h01)
    `CHK(ce_full, 1'b0)
    store_chk_en <= 1'b1;
    load(32'h10, da, 8'h01);
    `CHK(last_err, 1'b1)
    store_chk_en <= 1'b0;
    go(FE_PROG, 32'h100, 4'h0);
    `CHK(last_err, 1'b1)
    tib_lock <= 1'b0;
    go(FE_PROG, 32'h100, 4'h0);
    `CHK(last_err, 1'b0)
    go(FE_PROG, 32'h80, 4'h0);
    `CHK(last_err, 1'b1)
    meu_clr <= 1'b1;
    @(posedge hclk);
    meu_clr <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK(ce_cnt, 5'h00)
    idle_parts();
    blk_sel <= 8'h0A;
    blk_lock <= 8'h02;
    go(FE_ERASE, 32'h0, 4'h0);
    `CHK(part_busy, 5'h02)
    blk_lock <= 8'hF0;
    load(32'h20, da, 8'h03);
    go(FE_PROG, 32'h20, 4'h0);
    idle_parts();
    for (int i = 0; i < 6; i++)
    begin
      clr_seen <= 1'b1;
      @(posedge hclk);
      clr_seen <= 1'b0;
      go(FE_READ, 32'h20, modes[i]);
      repeat (2) @(posedge hclk);
      ahb(1'b0, `FE_R_STAT, 32'h0);
      `CHK({st[6:4], vseen}, exps[i])
      `CHK(esr_ext, exps[i][6])
      ahb(1'b1, `FE_R_CTRL, 32'h00000200);
      ahb(1'b0, `FE_R_STAT, 32'h0);
      `CHK(st[6:5], 2'b00)
    end
    load(32'h2C, {32'h0, db[31:0]}, 8'h00, 1'b0);
    go(FE_PROG, 32'h2C, 4'h0);
    idle_parts();
    go(FE_READ, 32'h2C, 4'h0, 1'b0);
    ahb(1'b0, `FE_R_RDLO, 32'h0);
    `CHK(st, db[31:0])
    ahb(1'b0, `FE_R_STAT, 32'h0);
    `CHK(st[2:1], 2'b00)
    `CHK(ue_valid, 1'b1)
    `CHK(ue_addr, 32'h20)
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(checkstop, 1'b0)
    `CHK(hresp, 1'b0)
    conclude();
  end
endmodule : flash_end_to_end_ecc_path_tb
